// File: hw/supervisor_pkg.sv
/*
 * Package for the reset cause and voltage supervisor: register offsets, field positions, reset values, timing.
 * Assumes a 20 MHz system clock and a byte-wide register view placed on 32-bit Wishbone words.
 */
package supervisor_pkg;
  // Printed offsets are not all multiples of four, so each is an index; byte address is index * 4
  localparam logic [19:0] IDX_WRITE_PROTECT   = 20'h0000A;
  localparam logic [19:0] IDX_RESET_CAUSE     = 20'h00018;
  localparam logic [19:0] IDX_DET_CONTROL     = 20'h0001A;
  localparam logic [19:0] IDX_DET_ENABLE      = 20'h00026;
  localparam logic [19:0] IDX_DET1_LEVEL      = 20'h00028;
  localparam logic [19:0] IDX_MON1_CONTROL    = 20'h0002B;
  localparam logic [19:0] IDX_MON2_CONTROL    = 20'h0002C;
  localparam logic [19:0] IDX_STARTUP_OPTION  = 20'hFFFFF;
  localparam logic [19:0] IDX_MON0_CONTROL    = 20'h00029;
  localparam logic [19:0] IDX_IRQ_STATUS      = 20'h00030;
  localparam logic [19:0] IDX_IRQ_MASK        = 20'h00031;
  localparam logic [19:0] IDX_DET_STATE       = 20'h00032;

  localparam int PROTECT_BIT3      = 3;
  localparam int CAUSE_HW          = 1;
  localparam int CAUSE_SW          = 2;
  localparam int CAUSE_WDT         = 3;
  localparam int CAUSE_MON1        = 4;
  localparam int CAUSE_MON2        = 5;
  localparam int CAUSE_OSC         = 6;
  localparam int CAUSE_MON0        = 0;
  localparam int CAUSE_POR         = 7;
  localparam int DET1_ENABLE_BIT   = 6;
  localparam int DET2_ENABLE_BIT   = 7;
  localparam int DET0_ENABLE_BIT   = 5;
  localparam int OPT_MON0_OFF_BIT  = 6;
  localparam int MON_ENABLE_BIT    = 0;
  localparam int MON_RESET_SEL_BIT = 6;
  localparam int IRQ_DET1          = 0;
  localparam int IRQ_DET2          = 1;

  localparam logic [7:0] RESET_ZERO       = 8'h00;
  localparam logic [7:0] CAUSE_POWER_ON   = 8'h80;
  localparam logic [7:0] OPTION_DEFAULT   = 8'hFF;

  localparam int CLK_HZ          = 20_000_000;
  localparam int OSC_LOW_HZ      = 125_000;
  localparam int OSC_DIV_CYCLES  = CLK_HZ / OSC_LOW_HZ;
  localparam int SAMPLE_AGREE    = 2;
endpackage

// File: hw/reset_cause_and_voltage_supervisor.sv
/*
 * Reset cause recording, write protect gate and three voltage detectors with interrupt and reset generation.
 * Assumes comparator outputs and reset requests arrive asynchronously; cause flags and the start-up
 * option byte sit in a retained domain cleared only by power-on (arst_n).
 * Assumes a classic Wishbone master that holds each request until it sees ack or err, and that
 * system_reset is routed to the rest of the chip but never back into arst_n, so the recorded
 * cause is still readable once the chip restarts.
 */
// Implementation choice: the Wishbone register port.
// Overview of operation
// - Detector and monitor registers accept writes only while protect bit 3 is set.
// - Hardware, software, watchdog, oscillator, monitor 0/1/2 and power-on resets are supported.
// - Cause bit 1 reads 1 after a hardware reset, else 0.
// - Cause bit 2 reads 1 after a software reset, else 0.
// - Cause bit 3 reads 1 after a watchdog timer reset, else 0.
// - Cause bit 4 reads 1 after a voltage monitor 1 reset, else 0.
// - Cause bit 5 reads 1 after a voltage monitor 2 reset, else 0.
// - Cause bit 6 reads 1 after an oscillator stop detect reset, else 0.
// - Detectors 1 and 2 can each raise a voltage detection interrupt.
// - Detectors 0, 1 and 2 can each raise a voltage detection reset.
// - Detectors sample only on the low-speed on-chip oscillator enable.
// - Detector control bit 6 enables or disables voltage detector 1.
// - Option bit 6 low enables monitor 0 reset after hardware reset; high disables it.
module reset_cause_and_voltage_supervisor
  import supervisor_pkg::*;
#(
  parameter int DIV_CYCLES = OSC_DIV_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [21:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        hw_reset_req,
  input  wire logic        sw_reset_req,
  input  wire logic        wdt_reset_req,
  input  wire logic        osc_stop_req,
  input  wire logic [2:0]  below_level,
  input  wire logic [7:0]  option_strap,
  output logic             system_reset,
  output logic             irq
);
  // Release is synchronous so no flop leaves reset a cycle before its neighbour
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Seven async inputs, three stages each; only stage 2 and 3 are compared
  localparam int NSYNC = 7;

  // All registered state of the block outside the retained domain
  typedef struct packed {
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    logic [NSYNC-1:0] level;
    logic [15:0]      div_cnt;
    logic [2:0]       det_prev;
    logic [2:0]       det_now;
    logic             strap_done;
    logic [7:0]       option;
    logic [7:0]       cause;
    logic [7:0]       protect;
    logic [7:0]       det_control;
    logic [7:0]       det_enable;
    logic [7:0]       det1_level;
    logic [7:0]       mon0_control;
    logic [7:0]       mon1_control;
    logic [7:0]       mon2_control;
    logic [7:0]       irq_status;
    logic [7:0]       irq_mask;
    logic             reset_out;
    logic             irq_out;
    logic [31:0]      rdata;
    logic             ack;
    logic             err;
  } state_t;

  // Retained part: cleared by power-on only so causes outlive internal resets
  typedef struct packed {
    logic [7:0] cause;
    logic [7:0] option;
    logic       strap_done;
  } keep_t;

  state_t s;
  state_t next_s;
  keep_t  k;
  keep_t  next_k;

  logic [NSYNC-1:0] raw_in;
  logic             sample_en;
  logic [19:0]      idx;
  logic             acc;
  logic             wr;
  logic             wr_lane0;
  logic             unlocked;
  logic [2:0]       det_on;
  logic [2:0]       falling;
  logic [2:0]       mon_reset;
  logic [7:0]       events;
  logic             mapped;

  assign raw_in = {below_level, osc_stop_req, wdt_reset_req, sw_reset_req, hw_reset_req};
  assign idx      = wb_adr_i[21:2];
  assign acc      = wb_cyc_i && wb_stb_i && !s.ack && !s.err;
  // A write lands at the edge where the master sees ack, while its data is still held
  assign wr       = wb_cyc_i && wb_stb_i && s.ack && wb_we_i;
  assign wr_lane0 = wr && wb_sel_i[0];
  assign unlocked = s.protect[PROTECT_BIT3];
  assign sample_en = (s.div_cnt == 16'(DIV_CYCLES - 1));

  always_comb begin
    // The option strap can arm monitor 0 before any software has run
    det_on[0] = s.det_control[DET0_ENABLE_BIT] || !k.option[OPT_MON0_OFF_BIT];
    det_on[1] = s.det_control[DET1_ENABLE_BIT];
    det_on[2] = s.det_control[DET2_ENABLE_BIT];
    // Interrupts fire on entry below a level, not for as long as it lasts
    falling   = s.det_now & ~s.det_prev;

    mon_reset[0] = det_on[0] && s.det_now[0];
    mon_reset[1] = det_on[1] && s.mon1_control[MON_ENABLE_BIT] && s.mon1_control[MON_RESET_SEL_BIT]
                   && s.det_now[1];
    mon_reset[2] = det_on[2] && s.mon2_control[MON_ENABLE_BIT] && s.mon2_control[MON_RESET_SEL_BIT]
                   && s.det_now[2];

    events = RESET_ZERO;
    events[IRQ_DET1] = falling[1] && det_on[1] && s.mon1_control[MON_ENABLE_BIT]
                       && !s.mon1_control[MON_RESET_SEL_BIT];
    events[IRQ_DET2] = falling[2] && det_on[2] && s.mon2_control[MON_ENABLE_BIT]
                       && !s.mon2_control[MON_RESET_SEL_BIT];

    // Unmapped indices answer with err so a stray pointer cannot pass unnoticed
    mapped = 1'b1;
    case (idx)
      IDX_WRITE_PROTECT,
      IDX_RESET_CAUSE,
      IDX_DET_CONTROL,
      IDX_DET_ENABLE,
      IDX_DET1_LEVEL,
      IDX_MON0_CONTROL,
      IDX_MON1_CONTROL,
      IDX_MON2_CONTROL,
      IDX_STARTUP_OPTION,
      IDX_IRQ_STATUS,
      IDX_IRQ_MASK,
      IDX_DET_STATE: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_k = k;
    // Strap is taken once after power-on; later changes on the pins are ignored
    if (!k.strap_done) begin
      next_k.option     = option_strap;
      next_k.strap_done = 1'b1;
    end

    // Set wins over a write-one clear in the same cycle
    if (wr_lane0 && idx == IDX_RESET_CAUSE) begin
      next_k.cause = k.cause & ~wb_dat_i[7:0];
    end

    // Hardware, software, watchdog and oscillator flags set while their synchronised level is high; monitor flags while mon_reset is high
    if (s.level[0]) begin
      next_k.cause[CAUSE_HW] = 1'b1;
    end
    if (s.level[1]) begin
      next_k.cause[CAUSE_SW] = 1'b1;
    end
    if (s.level[2]) begin
      next_k.cause[CAUSE_WDT] = 1'b1;
    end
    if (s.level[3]) begin
      next_k.cause[CAUSE_OSC] = 1'b1;
    end
    if (mon_reset[0]) begin
      next_k.cause[CAUSE_MON0] = 1'b1;
    end
    if (mon_reset[1]) begin
      next_k.cause[CAUSE_MON1] = 1'b1;
    end
    if (mon_reset[2]) begin
      next_k.cause[CAUSE_MON2] = 1'b1;
    end
  end

  always_comb begin
    next_s = s;
    next_s.sync1 = raw_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    // A change counts only once two stages agree, so a one-cycle glitch is dropped
    for (int i = 0; i < NSYNC; i++) begin
      if (s.sync2[i] == s.sync3[i]) begin
        next_s.level[i] = s.sync3[i];
      end
    end

    if (sample_en) begin
      next_s.div_cnt = 16'h0000;
    end else begin
      next_s.div_cnt = s.div_cnt + 16'h0001;
    end
    if (sample_en) begin
      next_s.det_prev = s.det_now;
      next_s.det_now  = s.level[6:4] & det_on;
    end

    // Read data is captured with the answer and holds until the next access
    next_s.ack = 1'b0;
    next_s.err = 1'b0;
    if (acc) begin
      next_s.ack   = mapped;
      next_s.err   = !mapped;
      next_s.rdata = 32'h0000_0000;
      case (idx)
        IDX_WRITE_PROTECT:  next_s.rdata[7:0] = s.protect;
        IDX_RESET_CAUSE:    next_s.rdata[7:0] = k.cause;
        IDX_DET_CONTROL:    next_s.rdata[7:0] = s.det_control;
        IDX_DET_ENABLE:     next_s.rdata[7:0] = s.det_enable;
        IDX_DET1_LEVEL:     next_s.rdata[7:0] = s.det1_level;
        IDX_MON0_CONTROL:   next_s.rdata[7:0] = s.mon0_control;
        IDX_MON1_CONTROL:   next_s.rdata[7:0] = s.mon1_control;
        IDX_MON2_CONTROL:   next_s.rdata[7:0] = s.mon2_control;
        IDX_STARTUP_OPTION: next_s.rdata[7:0] = k.option;
        IDX_IRQ_STATUS:     next_s.rdata[7:0] = s.irq_status;
        IDX_IRQ_MASK:       next_s.rdata[7:0] = s.irq_mask;
        IDX_DET_STATE:      next_s.rdata[7:0] = {5'b00000, s.det_now};
        default:            next_s.rdata[7:0] = RESET_ZERO;
      endcase
    end

    // Protected registers still answer, so a locked write is silently dropped
    if (wr_lane0) begin
      case (idx)
        IDX_WRITE_PROTECT: begin
          next_s.protect = wb_dat_i[7:0];
        end
        IDX_IRQ_MASK: begin
          next_s.irq_mask = wb_dat_i[7:0];
        end
        IDX_IRQ_STATUS: begin
          next_s.irq_status = s.irq_status & ~wb_dat_i[7:0];
        end
        IDX_DET_CONTROL: begin
          if (unlocked) begin
            next_s.det_control = wb_dat_i[7:0];
          end
        end
        IDX_DET_ENABLE: begin
          if (unlocked) begin
            next_s.det_enable = wb_dat_i[7:0];
          end
        end
        IDX_DET1_LEVEL: begin
          if (unlocked) begin
            next_s.det1_level = wb_dat_i[7:0];
          end
        end
        IDX_MON0_CONTROL: begin
          if (unlocked) begin
            next_s.mon0_control = wb_dat_i[7:0];
          end
        end
        IDX_MON1_CONTROL: begin
          if (unlocked) begin
            next_s.mon1_control = wb_dat_i[7:0];
          end
        end
        IDX_MON2_CONTROL: begin
          if (unlocked) begin
            next_s.mon2_control = wb_dat_i[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Mask gates the output only, so a masked event is still recorded
    next_s.irq_status = next_s.irq_status | events;
    next_s.irq_out    = |(next_s.irq_status & s.irq_mask);
    // Any active source drives the outgoing system reset request
    next_s.reset_out  = 1'b0;
    if (|s.level[3:0]) begin
      next_s.reset_out = 1'b1;
    end
    if (|mon_reset) begin
      next_s.reset_out = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      k.cause      <= CAUSE_POWER_ON;
      k.option     <= OPTION_DEFAULT;
      k.strap_done <= 1'b0;
    end else begin
      k <= next_k;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a register bit; nothing combinational reaches a pin
  assign wb_dat_o     = s.rdata;
  assign wb_ack_o     = s.ack;
  assign wb_err_o     = s.err;
  assign system_reset = s.reset_out;
  assign irq          = s.irq_out;
endmodule

// File: dv/supervisor_props.sv
/*
 * Checker for the supervisor: bus answer timing, error decode and reset request relations.
 * Sees only top-level ports; bound to every instance of the supervisor.
 */
module supervisor_props
  import supervisor_pkg::*;
#(
  parameter int DIV_CYCLES = OSC_DIV_CYCLES
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [21:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        hw_reset_req,
  input wire logic        sw_reset_req,
  input wire logic        wdt_reset_req,
  input wire logic        osc_stop_req,
  input wire logic        system_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mapped;
  logic take;
  logic req_on;
  logic any_req;
  assign mapped = wb_adr_i[21:2] inside {IDX_WRITE_PROTECT, IDX_RESET_CAUSE, IDX_DET_CONTROL, IDX_DET_ENABLE,
    IDX_DET1_LEVEL, IDX_MON0_CONTROL, IDX_MON1_CONTROL, IDX_MON2_CONTROL, IDX_STARTUP_OPTION,
    IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_DET_STATE};
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign req_on = wb_cyc_i && wb_stb_i;
  assign any_req = hw_reset_req || sw_reset_req || wdt_reset_req || osc_stop_req;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_ack_single:   assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_err_single:   assert property (wb_err_o |=> !wb_err_o) else $error("err held longer than one cycle");
  a_ack_mapped:   assert property (take && mapped |=> wb_ack_o && !wb_err_o) else $error("mapped access not acked");
  a_err_unmapped: assert property (take && !mapped |=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
  a_no_spurious:  assert property ((wb_ack_o || wb_err_o) |-> $past(req_on)) else $error("answer without request");
  a_read_width:   assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000) else $error("read upper bits set");
  a_src_reset:    assert property (any_req [*8] |-> system_reset) else $error("reset request not obeyed");
  a_quiet_start:  assert property ($rose(arst_n) |-> !wb_ack_o && !wb_err_o && !system_reset) else $error("outputs active at release");
endmodule

bind reset_cause_and_voltage_supervisor supervisor_props #(.DIV_CYCLES(DIV_CYCLES)) props (.clk, .arst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .hw_reset_req, .sw_reset_req, .wdt_reset_req,
  .osc_stop_req, .system_reset);

// File: dv/reset_cause_and_voltage_supervisor_tb.sv
/*
 * Self-checking bench for the supervisor: register table, reset causes, monitors and interrupt.
 * Drives ports directly; detector divider shortened to 4 so monitor waits stay short.
 */
module reset_cause_and_voltage_supervisor_tb
  import supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [21:0] a;
    logic        w;
    logic [7:0]  d;
  } row_t;
  localparam logic [21:0] PROT  = {IDX_WRITE_PROTECT, 2'b00};
  localparam logic [21:0] CAUSE = {IDX_RESET_CAUSE, 2'b00};
  localparam logic [21:0] DCTL  = {IDX_DET_CONTROL, 2'b00};
  localparam logic [21:0] OPT   = {IDX_STARTUP_OPTION, 2'b00};
  localparam logic [21:0] MON1  = {IDX_MON1_CONTROL, 2'b00};
  localparam logic [21:0] MON2  = {IDX_MON2_CONTROL, 2'b00};
  localparam logic [21:0] STAT  = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [21:0] MASK  = {IDX_IRQ_MASK, 2'b00};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [21:0] adr = 22'h000000;
  logic [7:0]  wd = 8'h00;
  logic [3:0]  req = 4'h0;
  logic [2:0]  below = 3'h0;
  logic [31:0] rd;
  logic        ack;
  logic        err;
  logic        srst;
  logic        irq;
  logic [7:0]  q;
  logic        e;
  logic [7:0]  cx;
  int          n_errors = 0;
  int          checks_done = 0;
  int          bits [4] = '{CAUSE_HW, CAUSE_SW, CAUSE_WDT, CAUSE_OSC};
  // Writes before protect is set must be dropped; option byte is strapped to 0xFF
  row_t        rows [10] = '{'{CAUSE, 1'b0, 8'h80}, '{DCTL, 1'b1, 8'h40}, '{DCTL, 1'b0, 8'h00},
    '{PROT, 1'b1, 8'h08}, '{PROT, 1'b0, 8'h08}, '{DCTL, 1'b1, 8'h40}, '{DCTL, 1'b0, 8'h40},
    '{OPT, 1'b1, 8'h00}, '{OPT, 1'b0, 8'hFF}, '{MASK, 1'b0, 8'h00}};

  always #25 clk = ~clk;

  reset_cause_and_voltage_supervisor #(.DIV_CYCLES(4)) uut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h000000, wd}), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .hw_reset_req(req[0]), .sw_reset_req(req[1]), .wdt_reset_req(req[2]),
    .osc_stop_req(req[3]), .below_level(below), .option_strap(8'hFF), .system_reset(srst), .irq(irq));

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic bus(input logic [21:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = rd[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    final_report;
  end

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      bus(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("register", rows[i].d, q);
    end
    $display("register table done");
    bus(CAUSE, 1'b1, 8'hFF);
    cx = 8'h00;
    for (int i = 0; i < 4; i++) begin
      req[i] <= 1'b1;
      repeat (8) @(posedge clk);
      chk("system_reset", 8'h01, {7'h00, srst});
      req[i] <= 1'b0;
      repeat (8) @(posedge clk);
      cx[bits[i]] = 1'b1;
      bus(CAUSE, 1'b0, 8'h00);
      chk("cause", cx, q);
    end
    $display("reset sources done");
    bus(MON1, 1'b1, 8'h41);
    bus(MON2, 1'b1, 8'h41);
    bus(DCTL, 1'b1, 8'hC0);
    // Monitor 0 stays off: option bit 6 is high and its enable bit is clear
    for (int k = 0; k < 3; k++) begin
      below[k] <= 1'b1;
      repeat (40) @(posedge clk);
      chk("monitor reset", {7'h00, k != 0}, {7'h00, srst});
      below[k] <= 1'b0;
      repeat (40) @(posedge clk);
      if (k != 0) cx[k + 3] = 1'b1;
      bus(CAUSE, 1'b0, 8'h00);
      chk("cause", cx, q);
    end
    $display("monitor resets done");
    bus(MON1, 1'b1, 8'h01);
    bus(MON2, 1'b1, 8'h01);
    bus(STAT, 1'b1, 8'h03);
    bus(MASK, 1'b1, 8'h01);
    below <= 3'h6;
    repeat (40) @(posedge clk);
    chk("irq", 8'h01, {7'h00, irq});
    bus(STAT, 1'b0, 8'h00);
    chk("irq status", 8'h03, q);
    bus(MASK, 1'b1, 8'h00);
    repeat (3) @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, irq});
    bus(MASK, 1'b1, 8'h02);
    repeat (3) @(posedge clk);
    chk("irq second", 8'h01, {7'h00, irq});
    below <= 3'h0;
    repeat (40) @(posedge clk);
    bus(STAT, 1'b1, 8'h03);
    repeat (3) @(posedge clk);
    chk("irq cleared", 8'h00, {7'h00, irq});
    $display("interrupt done");
    bus(22'h000004, 1'b0, 8'h00);
    chk("unmapped err", 8'h01, {7'h00, e});
    $display("unmapped access done");
    final_report;
  end
endmodule
